/* File: verilog/ewl_pkg.sv */
package ewl_pkg;

  // ------------------------------------------------------------
  // Lock mask bit positions
  // ------------------------------------------------------------
  localparam int SELF_LOCK_BIT            = 15;
  localparam int STD_WP_LOCK_BIT          = 14;
  localparam int TRIM_LOCK_BIT            = 13;
  localparam int VOUT_LOCK_BIT            = 12;
  localparam int VOUT_FAULT_LOCK_BIT      = 11;
  localparam int WARN_LIMIT_LOCK_BIT      = 10;
  localparam int CURRENT_TEMP_FAULT_LOCK_BIT = 9;
  localparam int MARGIN_LOCK_BIT          = 8;
  localparam int OPERATION_LOCK_BIT       = 7;
  localparam int CONFIG_LOCK_BIT          = 6;
  localparam int INPUT_LIMIT_LOCK_BIT     = 5;
  localparam int SEQUENCING_LOCK_BIT      = 4;
  localparam int IDENTITY_DATA_LOCK_BIT   = 3;
  localparam int BOOT_SETTING_LOCK_BIT    = 2;
  localparam int UNLOCK_CODE_LOCK_BIT     = 1;
  localparam int NVM_STORE_LOCK_BIT       = 0;

  localparam int          MASK_W        = 16;
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [15:0] NO_GROUP      = 16'h0000;

  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_OPERATION        = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG       = 8'h02;
  localparam logic [7:0] CMD_STD_WP           = 8'h10;
  localparam logic [7:0] CMD_STORE_ALL        = 8'h15;
  localparam logic [7:0] CMD_ALERT_MASK       = 8'h1b;
  localparam logic [7:0] CMD_VOUT_MODE        = 8'h20;
  localparam logic [7:0] CMD_VOUT_SET         = 8'h21;
  localparam logic [7:0] CMD_VOUT_TRIM        = 8'h22;
  localparam logic [7:0] CMD_VOUT_MAX         = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH      = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW       = 8'h26;
  localparam logic [7:0] CMD_TRANS_RATE       = 8'h27;
  localparam logic [7:0] CMD_SCALE_LOOP       = 8'h29;
  localparam logic [7:0] CMD_VOUT_MIN         = 8'h2b;
  localparam logic [7:0] CMD_FREQ_SWITCH      = 8'h33;
  localparam logic [7:0] CMD_VIN_ON           = 8'h35;
  localparam logic [7:0] CMD_VIN_OFF          = 8'h36;
  localparam logic [7:0] CMD_PHASE_SETTING_A  = 8'h37;
  localparam logic [7:0] CMD_CAL_GAIN         = 8'h38;
  localparam logic [7:0] CMD_CAL_OFFSET       = 8'h39;
  localparam logic [7:0] CMD_VOUT_OV_FLT      = 8'h40;
  localparam logic [7:0] CMD_VOUT_OV_RSP      = 8'h41;
  localparam logic [7:0] CMD_VOUT_OV_WARN     = 8'h42;
  localparam logic [7:0] CMD_VOUT_UV_WARN     = 8'h43;
  localparam logic [7:0] CMD_VOUT_UV_FLT      = 8'h44;
  localparam logic [7:0] CMD_VOUT_UV_RSP      = 8'h45;
  localparam logic [7:0] CMD_IOUT_OC_FLT      = 8'h46;
  localparam logic [7:0] CMD_IOUT_OC_RSP      = 8'h47;
  localparam logic [7:0] CMD_IOUT_OC_WARN     = 8'h4a;
  localparam logic [7:0] CMD_OT_FLT           = 8'h4f;
  localparam logic [7:0] CMD_OT_RSP           = 8'h50;
  localparam logic [7:0] CMD_OT_WARN          = 8'h51;
  localparam logic [7:0] CMD_VIN_OV_FLT       = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_RSP       = 8'h56;
  localparam logic [7:0] CMD_VIN_OV_WARN      = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN      = 8'h58;
  localparam logic [7:0] CMD_TON_DELAY        = 8'h60;
  localparam logic [7:0] CMD_TON_RISE         = 8'h61;
  localparam logic [7:0] CMD_TON_MAX_FLT      = 8'h62;
  localparam logic [7:0] CMD_TON_MAX_RSP      = 8'h63;
  localparam logic [7:0] CMD_TOFF_DELAY       = 8'h64;
  localparam logic [7:0] CMD_TOFF_FALL        = 8'h65;
  localparam logic [7:0] CMD_MFR_IDENT        = 8'h99;
  localparam logic [7:0] CMD_MFR_MODEL        = 8'h9a;
  localparam logic [7:0] CMD_MFR_REV          = 8'h9b;
  localparam logic [7:0] CMD_MFR_SERIAL       = 8'h9e;
  localparam logic [7:0] CMD_LOOP_COMP        = 8'hd0;
  localparam logic [7:0] CMD_TRANSIENT        = 8'hd1;
  localparam logic [7:0] CMD_TELEMETRY        = 8'hd2;
  localparam logic [7:0] CMD_POWER_STAGE      = 8'hd3;
  localparam logic [7:0] CMD_POWER_GOOD       = 8'hd4;
  localparam logic [7:0] CMD_SYNC_CFG         = 8'hd5;
  localparam logic [7:0] CMD_MISC_OPT         = 8'hd6;
  localparam logic [7:0] CMD_STACK_CFG        = 8'hd7;
  localparam logic [7:0] CMD_STRAP_OVERRIDE   = 8'hd8;
  localparam logic [7:0] CMD_BUS_ADDRESS      = 8'hd9;
  localparam logic [7:0] CMD_SIM_FAULTS       = 8'hda;
  localparam logic [7:0] CMD_UNLOCK_CODE      = 8'hfa;
  localparam logic [7:0] CMD_EXT_LOCK_MASK    = 8'hfb;

endpackage

/* File: verilog/ewl_cmd_group.sv */
`timescale 1ns/1ns
`default_nettype none

module ewl_cmd_group
  import ewl_pkg::*;
(
  // Command under test
  input  wire logic [7:0]  cmd_code,
  // Lock group bits of the command; the unlock code command sets two, unlisted codes none
  output logic      [15:0] group_sel
);

  // ------------------------------------------------------------
  // Group decode
  // ------------------------------------------------------------
  function automatic logic [15:0] group_of(input logic [7:0] code);
    logic [15:0] g;
    g = NO_GROUP;
    case (code)
      CMD_EXT_LOCK_MASK, CMD_UNLOCK_CODE:
        g[SELF_LOCK_BIT] = 1'b1;
      CMD_STD_WP:
        g[STD_WP_LOCK_BIT] = 1'b1;
      CMD_VOUT_TRIM, CMD_SCALE_LOOP, CMD_CAL_GAIN, CMD_CAL_OFFSET:
        g[TRIM_LOCK_BIT] = 1'b1;
      CMD_VOUT_MODE, CMD_VOUT_SET:
        g[VOUT_LOCK_BIT] = 1'b1;
      CMD_VOUT_MAX, CMD_VOUT_OV_FLT, CMD_VOUT_OV_RSP, CMD_VOUT_UV_FLT,
      CMD_VOUT_UV_RSP, CMD_VOUT_MIN:
        g[VOUT_FAULT_LOCK_BIT] = 1'b1;
      CMD_VOUT_OV_WARN, CMD_VOUT_UV_WARN, CMD_IOUT_OC_WARN, CMD_OT_WARN,
      CMD_ALERT_MASK:
        g[WARN_LIMIT_LOCK_BIT] = 1'b1;
      CMD_IOUT_OC_FLT, CMD_IOUT_OC_RSP, CMD_OT_FLT, CMD_OT_RSP, CMD_SIM_FAULTS:
        g[CURRENT_TEMP_FAULT_LOCK_BIT] = 1'b1;
      CMD_MARGIN_HIGH, CMD_MARGIN_LOW, CMD_TRANS_RATE:
        g[MARGIN_LOCK_BIT] = 1'b1;
      CMD_OPERATION:
        g[OPERATION_LOCK_BIT] = 1'b1;
      CMD_FREQ_SWITCH, CMD_PHASE_SETTING_A, CMD_LOOP_COMP, CMD_TRANSIENT,
      CMD_TELEMETRY, CMD_POWER_STAGE, CMD_POWER_GOOD, CMD_SYNC_CFG,
      CMD_MISC_OPT, CMD_STACK_CFG:
        g[CONFIG_LOCK_BIT] = 1'b1;
      CMD_VIN_UV_WARN, CMD_VIN_OV_FLT, CMD_VIN_OV_WARN, CMD_VIN_OV_RSP:
        g[INPUT_LIMIT_LOCK_BIT] = 1'b1;
      CMD_TON_DELAY, CMD_TON_RISE, CMD_TON_MAX_FLT, CMD_TON_MAX_RSP,
      CMD_TOFF_DELAY, CMD_TOFF_FALL, CMD_ON_OFF_CFG, CMD_VIN_ON, CMD_VIN_OFF:
        g[SEQUENCING_LOCK_BIT] = 1'b1;
      CMD_MFR_IDENT, CMD_MFR_MODEL, CMD_MFR_REV, CMD_MFR_SERIAL:
        g[IDENTITY_DATA_LOCK_BIT] = 1'b1;
      CMD_STRAP_OVERRIDE, CMD_BUS_ADDRESS:
        g[BOOT_SETTING_LOCK_BIT] = 1'b1;
      CMD_STORE_ALL:
        g[NVM_STORE_LOCK_BIT] = 1'b1;
      default:
        g = NO_GROUP;
    endcase
    // The passkey command is governed by both the self lock and its own bit.
    if (code == CMD_UNLOCK_CODE)
    begin
      g[UNLOCK_CODE_LOCK_BIT] = 1'b1;
    end
    return g;
  endfunction

  assign group_sel = group_of(cmd_code);

endmodule

`default_nettype wire

/* File: verilog/ewl_ext_cmd_write_protect.sv */
`timescale 1ns/1ns
`default_nettype none

module ewl_ext_cmd_write_protect
  import ewl_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // Write request from the command decoder
  input  wire logic                wr_valid,
  input  wire logic [7:0]          wr_code,
  input  wire logic [15:0]         wr_data,
  // Write verdict
  output logic                     wr_accept,
  output logic                     wr_refuse,
  // Protection held by neighbouring logic
  input  wire logic                std_wp_deny,
  input  wire logic                unlock_code_locked,
  input  wire logic                unlock_code_nonzero,
  // Non-volatile memory load and store completion
  input  wire logic                nvm_load,
  input  wire logic [15:0]         nvm_mask,
  input  wire logic                nvm_store_done,
  // Mask state
  output logic      [15:0]         extended_write_lock_mask,
  output logic                     perm_lock
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] mask_r;
  logic        perm_lock_r;
  logic        store_pending_r;
  logic [15:0] group_sel;
  logic        group_locked;
  logic        self_target;
  logic        store_target;
  logic        code_target;
  logic        unlock_deny;
  logic        perm_nxt;

  ewl_cmd_group u_group
  (
    .cmd_code  (wr_code),
    .group_sel (group_sel)
  );

  // ------------------------------------------------------------
  // Write verdict
  // ------------------------------------------------------------
  assign self_target  = (wr_code == CMD_EXT_LOCK_MASK);
  assign store_target = (wr_code == CMD_STORE_ALL);
  assign code_target  = (wr_code == CMD_UNLOCK_CODE);
  // Every bit acts on its own group only.
  assign group_locked = |(group_sel & mask_r);
  assign unlock_deny  = unlock_code_locked && (self_target || store_target);

  always_comb
  begin
    wr_accept = wr_valid && !group_locked && !std_wp_deny && !unlock_deny;
    if (self_target && perm_lock_r)
    begin
      wr_accept = 1'b0;
    end
    wr_refuse = wr_valid && !wr_accept;
  end

  // ------------------------------------------------------------
  // Mask register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      mask_r <= MASK_RESET;
    end
    else if (nvm_load)
    begin
      mask_r <= nvm_mask;
    end
    else if (wr_accept && self_target)
    begin
      mask_r <= wr_data;
    end
  end

  // ------------------------------------------------------------
  // Permanent lock
  // ------------------------------------------------------------
  // The lock is armed when a store is taken and fires when it completes,
  // so a refused store never locks anything.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      store_pending_r <= 1'b0;
    end
    else if (wr_accept && store_target)
    begin
      store_pending_r <= 1'b1;
    end
    else if (nvm_store_done)
    begin
      store_pending_r <= 1'b0;
    end
  end

  always_comb
  begin
    perm_nxt = perm_lock_r;
    if (store_pending_r && nvm_store_done)
    begin
      if (mask_r[SELF_LOCK_BIT])
      begin
        perm_nxt = 1'b1;
      end
      if (mask_r[UNLOCK_CODE_LOCK_BIT] && unlock_code_nonzero)
      begin
        perm_nxt = 1'b1;
      end
    end
    // A boot image that already holds either locking state stays locked.
    if (nvm_load && (nvm_mask[SELF_LOCK_BIT]
        || (nvm_mask[UNLOCK_CODE_LOCK_BIT] && unlock_code_nonzero)))
    begin
      perm_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      perm_lock_r <= 1'b0;
    end
    else
    begin
      perm_lock_r <= perm_nxt;
    end
  end

  assign extended_write_lock_mask = mask_r;
  assign perm_lock                = perm_lock_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_warn_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid && mask_r[WARN_LIMIT_LOCK_BIT] && (wr_code == CMD_OT_WARN) |-> !wr_accept)
    else $error("warning limit write passed a set lock bit");

  chk_fault_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid && mask_r[CURRENT_TEMP_FAULT_LOCK_BIT] && (wr_code == CMD_SIM_FAULTS)
    |-> wr_refuse)
    else $error("fault simulation write passed a set lock bit");

  chk_operation_open: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid && (wr_code == CMD_OPERATION) && !mask_r[OPERATION_LOCK_BIT] && !std_wp_deny
    |-> wr_accept)
    else $error("operation write refused with lock bit clear");

  chk_code_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid && code_target && mask_r[UNLOCK_CODE_LOCK_BIT] |-> !wr_accept)
    else $error("unlock code write passed a set lock bit");

  chk_store_open: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid && store_target && !mask_r[NVM_STORE_LOCK_BIT] && !std_wp_deny
    && !unlock_code_locked |-> wr_accept)
    else $error("store refused with nothing forbidding it");

  chk_store_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid && store_target && mask_r[NVM_STORE_LOCK_BIT] |-> wr_refuse)
    else $error("store accepted with store lock set");

  chk_mask_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_accept && self_target && !nvm_load |=> mask_r == $past(wr_data))
    else $error("accepted mask write not stored");

  chk_refused_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_refuse && self_target && !nvm_load |=> $stable(mask_r))
    else $error("refused mask write changed the mask");

  chk_unlock_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid && unlock_code_locked && (self_target || store_target) |-> !wr_accept)
    else $error("mask or store write passed a held unlock code");

  chk_perm_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    perm_lock_r |=> perm_lock_r [*3])
    else $error("permanent lock released");

  chk_perm_blocks: assert property (@(posedge sys_clk) disable iff (!resetn)
    perm_lock_r && wr_valid && self_target && !nvm_load |-> wr_refuse ##1 $stable(mask_r))
    else $error("mask writable under permanent lock");

  chk_self_arms: assert property (@(posedge sys_clk) disable iff (!resetn)
    store_pending_r && nvm_store_done && mask_r[SELF_LOCK_BIT] |=> perm_lock_r)
    else $error("stored self lock did not lock permanently");

  chk_load_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
    nvm_load |=> mask_r == $past(nvm_mask))
    else $error("mask did not take the loaded image");

endmodule

`default_nettype wire

/* File: tb/ewl_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

module ewl_host_model
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Request from the bench
  input  wire logic        req,
  input  wire logic [7:0]  req_code,
  input  wire logic [15:0] req_data,
  // Write towards the block
  output logic             wr_valid,
  output logic      [7:0]  wr_code,
  output logic      [15:0] wr_data
);
  // ----------------------------------------------------------
  // Write issue
  // ----------------------------------------------------------
  // Between writes code and data flip every cycle, so a stale word never looks valid.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wr_valid <= 1'b0;
      wr_code  <= 8'h00;
      wr_data  <= 16'h0000;
    end
    else if (!req)
    begin
      wr_valid <= 1'b0;
      wr_code  <= ~wr_code;
      wr_data  <= ~wr_data;
    end
    else
    begin
      wr_valid <= 1'b1;
      wr_code  <= req_code;
      wr_data  <= req_data;
    end
  end
endmodule

`default_nettype wire

/* File: tb/tb_ext_cmd_write_protect.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_ext_cmd_write_protect
  import ewl_pkg::*;
;
  logic        sys_clk, resetn, req, wr_valid, wr_accept, wr_refuse, perm_lock;
  logic        std_wp_deny, unlock_code_locked, unlock_code_nonzero, nvm_load, nvm_store_done;
  logic [7:0]  req_code, wr_code, c;
  logic [15:0] req_data, wr_data, nvm_mask, extended_write_lock_mask, exp_mask, d;
  logic        exp_perm;
  int          seed = 32'h49fc421e;
  int          num_errors = 0;
  int          num_checks = 0;
  localparam int NCODES = 24;
  localparam logic [7:0] CODES [NCODES] = '{CMD_VOUT_OV_WARN, CMD_ALERT_MASK, CMD_IOUT_OC_FLT,
    CMD_SIM_FAULTS, CMD_MARGIN_HIGH, CMD_TRANS_RATE, CMD_OPERATION, CMD_FREQ_SWITCH,
    CMD_STACK_CFG, CMD_VIN_UV_WARN, CMD_VIN_OV_RSP, CMD_TON_DELAY, CMD_VIN_OFF, CMD_MFR_IDENT,
    CMD_MFR_SERIAL, CMD_STRAP_OVERRIDE, CMD_BUS_ADDRESS, CMD_UNLOCK_CODE, CMD_STORE_ALL,
    CMD_EXT_LOCK_MASK, CMD_VOUT_MODE, CMD_VOUT_MAX, CMD_VOUT_TRIM, CMD_STD_WP};

  ewl_host_model host (.sys_clk(sys_clk), .resetn(resetn), .req(req), .req_code(req_code),
    .req_data(req_data), .wr_valid(wr_valid), .wr_code(wr_code), .wr_data(wr_data));

  ewl_ext_cmd_write_protect dut (.sys_clk(sys_clk), .resetn(resetn), .wr_valid(wr_valid),
    .wr_code(wr_code), .wr_data(wr_data), .wr_accept(wr_accept), .wr_refuse(wr_refuse),
    .std_wp_deny(std_wp_deny), .unlock_code_locked(unlock_code_locked),
    .unlock_code_nonzero(unlock_code_nonzero), .nvm_load(nvm_load), .nvm_mask(nvm_mask),
    .nvm_store_done(nvm_store_done), .extended_write_lock_mask(extended_write_lock_mask),
    .perm_lock(perm_lock));

  // ----------------------------------------------------------
  // Expectation and checking
  // ----------------------------------------------------------
  function automatic int grp(input logic [7:0] k);
    case (k)
      CMD_VOUT_OV_WARN, CMD_ALERT_MASK:   return WARN_LIMIT_LOCK_BIT;
      CMD_IOUT_OC_FLT, CMD_SIM_FAULTS:    return CURRENT_TEMP_FAULT_LOCK_BIT;
      CMD_MARGIN_HIGH, CMD_TRANS_RATE:    return MARGIN_LOCK_BIT;
      CMD_OPERATION:                      return OPERATION_LOCK_BIT;
      CMD_FREQ_SWITCH, CMD_STACK_CFG:     return CONFIG_LOCK_BIT;
      CMD_VIN_UV_WARN, CMD_VIN_OV_RSP:    return INPUT_LIMIT_LOCK_BIT;
      CMD_TON_DELAY, CMD_VIN_OFF:         return SEQUENCING_LOCK_BIT;
      CMD_MFR_IDENT, CMD_MFR_SERIAL:      return IDENTITY_DATA_LOCK_BIT;
      CMD_STRAP_OVERRIDE, CMD_BUS_ADDRESS: return BOOT_SETTING_LOCK_BIT;
      CMD_UNLOCK_CODE:                    return UNLOCK_CODE_LOCK_BIT;
      CMD_STORE_ALL:                      return NVM_STORE_LOCK_BIT;
      CMD_VOUT_MODE:                      return VOUT_LOCK_BIT;
      CMD_VOUT_MAX:                       return VOUT_FAULT_LOCK_BIT;
      CMD_VOUT_TRIM:                      return TRIM_LOCK_BIT;
      CMD_STD_WP:                         return STD_WP_LOCK_BIT;
      default:                            return -1;
    endcase
  endfunction

  function automatic logic exp_ok(input logic [7:0] k);
    int   g;
    logic ok;
    g  = grp(k);
    ok = !std_wp_deny && !(g >= 0 && exp_mask[g]);
    if (k == CMD_UNLOCK_CODE && exp_mask[SELF_LOCK_BIT]) ok = 1'b0;
    if ((k == CMD_EXT_LOCK_MASK || k == CMD_STORE_ALL) && unlock_code_locked) ok = 1'b0;
    if (k == CMD_EXT_LOCK_MASK && (exp_mask[SELF_LOCK_BIT] || exp_perm)) ok = 1'b0;
    return ok;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------
  task automatic write(input logic [7:0] k, input logic [15:0] v);
    logic ok;
    @(posedge sys_clk);
    req      <= 1'b1;
    req_code <= k;
    req_data <= v;
    @(posedge sys_clk);
    req <= 1'b0;
    @(negedge sys_clk);
    ok = exp_ok(k);
    check(16'(wr_accept), 16'(ok));
    check(16'(wr_refuse), 16'(!ok));
    if (ok && k == CMD_EXT_LOCK_MASK) exp_mask = v;
    if (ok && k == CMD_STORE_ALL)
    begin
      @(posedge sys_clk);
      nvm_store_done <= 1'b1;
      @(posedge sys_clk);
      nvm_store_done <= 1'b0;
      exp_perm = exp_perm | exp_mask[SELF_LOCK_BIT]
        | (exp_mask[UNLOCK_CODE_LOCK_BIT] & unlock_code_nonzero);
    end
    @(negedge sys_clk);
    check(extended_write_lock_mask, exp_mask);
    check(16'(perm_lock), 16'(exp_perm));
  endtask

  task automatic load(input logic [15:0] v);
    @(posedge sys_clk);
    nvm_load <= 1'b1;
    nvm_mask <= v;
    @(posedge sys_clk);
    nvm_load <= 1'b0;
    nvm_mask <= ~v;
    exp_mask = v;
    exp_perm = exp_perm | v[SELF_LOCK_BIT] | (v[UNLOCK_CODE_LOCK_BIT] & unlock_code_nonzero);
    @(negedge sys_clk);
    check(extended_write_lock_mask, exp_mask);
    check(16'(perm_lock), 16'(exp_perm));
  endtask

  task automatic do_reset(input int n);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (n) @(posedge sys_clk);
    resetn   <= 1'b1;
    exp_mask = MASK_RESET;
    exp_perm = 1'b0;
    @(negedge sys_clk);
    check(extended_write_lock_mask, exp_mask);
    check(16'(perm_lock), 16'(exp_perm));
  endtask

  // ----------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #900000;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    {resetn, req, req_code, req_data, nvm_load, nvm_mask, nvm_store_done} = '0;
    {std_wp_deny, unlock_code_locked, unlock_code_nonzero} = '0;
    do_reset(12);
    // Each group bit alone, every listed command, then the self lock bit.
    for (int b = 0; b < 16; b++)
    begin
      d = 16'h0001 << b;
      load(d);
      for (int j = 0; j < NCODES; j++) write(CODES[j], d);
    end
    $display("test group_bits done");
    // A locking image loaded with a nonzero unlock code sets the permanent lock.
    do_reset(2);
    @(posedge sys_clk);
    unlock_code_nonzero <= 1'b1;
    load(16'h0002);
    write(CMD_EXT_LOCK_MASK, 16'h0000);
    $display("test load_lock done");
    for (int i = 0; i < 400; i++)
    begin
      if (i == 200) do_reset(3);
      @(posedge sys_clk);
      std_wp_deny         <= ($random(seed) & 7) == 0;
      unlock_code_locked  <= ($random(seed) & 3) == 0;
      unlock_code_nonzero <= 1'($random(seed));
      c = CODES[$unsigned($random(seed)) % NCODES];
      d = 16'($random(seed));
      if (i % 16 != 0) d[15] = 1'b0;
      write(c, d);
    end
    $display("test random done");
    end_of_test();
  end
endmodule

`default_nettype wire
